//--- verilog/sfm_pkg.sv
// Package of constants and types for the supply fault monitor.
package sfm_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    // Filter times in nanoseconds; the cycle count is rounded up.
    localparam int unsigned VCC_UV_NS = 10000;
    localparam int unsigned VB_UV_NS = 10000;
    localparam int unsigned CP_OV_NS = 10000;
    localparam int unsigned VCC_OV_NS = 10000;
    localparam int unsigned OPSUP_UV_NS = 10000;
    localparam int unsigned VCC_UV_CYC = (VCC_UV_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned VB_UV_CYC = (VB_UV_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CP_OV_CYC = (CP_OV_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned VCC_OV_CYC = (VCC_OV_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned OPSUP_UV_CYC = (OPSUP_UV_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned FILT_W = 16;
    localparam int unsigned MODE_W = 3;

    typedef enum logic [2:0] {
        SFM_MODE_NOTIFY = 3'h0,
        SFM_MODE_CONT   = 3'h1,
        SFM_MODE_ALL9   = 3'h2,
        SFM_MODE_MOT6   = 3'h3,
        SFM_MODE_ALLCP  = 3'h4,
        SFM_MODE_HOLD   = 3'h5
    } sfm_mode_t;

    typedef enum logic [1:0] {
        SFM_ST_RUN  = 2'h0,
        SFM_ST_UV   = 2'h1,
        SFM_ST_BIST = 2'h2,
        SFM_ST_FAIL = 2'h3
    } sfm_state_t;

    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
endpackage : sfm_pkg

//--- verilog/sfm_supply_fault_monitor.sv
// Supply fault monitor: filters, status bits, response modes and diagnostic output.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - VCC undervoltage is OR of both comparators
// - VCC undervoltage: flags, reset, shutdown everything
// - After VCC recovery run self-tests, gate restart
// - Diagnostic high on self-test pass, low fail
// - Deep VCC drop enters standby
// - VB undervoltage filtered, nine pre-drivers off
// - VB recovery resumes without status clear
// - Host clears VB status, diagnostic returns high
// - Clears ignored while fault present
// - Six selectable response modes for CP OV, VCC OV and op-amp UV monitors
// - Mode change applies after fault and clear
// - Mode 000 raises the flag only, sets no status, keeps running
// - Mode 101 holds shutdown until status clear
// - Modes 001-100 resume, status retained
// - Charge pump overvoltage flag after filter
// - VCC overvoltage filtered with mode policy
// - Op-amp supply undervoltage filtered with policy
// - Status held until clear bit written
// - Diagnostic high only when all status clear
module sfm_supply_fault_monitor
    import sfm_pkg::*;
#(
    parameter int unsigned VCC_UV_FILT   = VCC_UV_CYC,
    parameter int unsigned VB_UV_FILT    = VB_UV_CYC,
    parameter int unsigned CP_OV_FILT    = CP_OV_CYC,
    parameter int unsigned VCC_OV_FILT   = VCC_OV_CYC,
    parameter int unsigned OPSUP_UV_FILT = OPSUP_UV_CYC
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Comparator inputs.
    input  wire logic              vcc_uv_cmp_a,
    input  wire logic              vcc_uv_cmp_b,
    input  wire logic              vcc_deep_uv,
    input  wire logic              vb_uv_cmp,
    input  wire logic              cp_ov_cmp,
    input  wire logic              vcc_ov_cmp,
    input  wire logic              opsup_uv_cmp,
    // Mode settings written by the host.
    input  wire logic [MODE_W-1:0] cp_ov_mode,
    input  wire logic [MODE_W-1:0] vcc_ov_mode,
    input  wire logic [MODE_W-1:0] opsup_uv_mode,
    // Status clear pulses written by the host.
    input  wire logic              vb_uv_clr,
    input  wire logic              cp_ov_clr,
    input  wire logic              vcc_ov_clr,
    input  wire logic              opsup_uv_clr,
    // Self-test handshake.
    output logic                   self_test_start,
    input  wire logic              self_test_done,
    input  wire logic              logic_self_test,
    input  wire logic              analog_self_test,
    // Filtered flags.
    output logic                   vcc_uv_flag_a,
    output logic                   vcc_uv_flag_b,
    output logic                   vb_uv_flag,
    output logic                   cp_ov_flag,
    output logic                   vcc_ov_flag,
    output logic                   opsup_uv_flag,
    // Status bits.
    output logic                   vb_uv_stat,
    output logic                   cp_ov_stat,
    output logic                   vcc_ov_stat,
    output logic                   opsup_uv_stat,
    // Responses.
    output logic                   por_n,
    output logic                   standby,
    output logic                   motor_drv_en,
    output logic                   relay_drv_en,
    output logic                   cp_en,
    output logic                   osc_en,
    output logic                   diag_out_n
);

    // Counts up to the limit and holds there while the input holds, restarts when it drops.
    function automatic logic [FILT_W-1:0] filt_next(input logic in, input logic [FILT_W-1:0] cnt,
                                                    input logic [FILT_W-1:0] lim);
        if (!in) begin
            filt_next = '0;
        end else if (cnt < lim) begin
            filt_next = cnt + 16'h1;
        end else begin
            filt_next = cnt;
        end
    endfunction : filt_next

    logic [FILT_W-1:0] vcc_uv_cnt_ff;
    logic [FILT_W-1:0] vb_cnt_ff;
    logic [FILT_W-1:0] cp_cnt_ff;
    logic [FILT_W-1:0] vov_cnt_ff;
    logic [FILT_W-1:0] op_cnt_ff;
    logic              vcc_uv_ff;
    logic              vb_ff;
    logic              cp_ff;
    logic              vov_ff;
    logic              op_ff;
    logic              vcc_uv_raw;
    sfm_state_t        state_ff;
    sfm_state_t        nxt_state;
    logic [MODE_W-1:0] cp_mode_ff;
    logic [MODE_W-1:0] vov_mode_ff;
    logic [MODE_W-1:0] op_mode_ff;
    logic              start_ff;

    assign vcc_uv_raw = vcc_uv_cmp_a | vcc_uv_cmp_b;

    // One counter per monitor, so that each restarts on its own input alone.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vcc_uv_cnt_ff <= '0;
        end else begin
            vcc_uv_cnt_ff <= filt_next(vcc_uv_raw, vcc_uv_cnt_ff, FILT_W'(VCC_UV_FILT));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vb_cnt_ff <= '0;
        end else begin
            vb_cnt_ff <= filt_next(vb_uv_cmp, vb_cnt_ff, FILT_W'(VB_UV_FILT));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_cnt_ff <= '0;
        end else begin
            cp_cnt_ff <= filt_next(cp_ov_cmp, cp_cnt_ff, FILT_W'(CP_OV_FILT));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vov_cnt_ff <= '0;
        end else begin
            vov_cnt_ff <= filt_next(vcc_ov_cmp, vov_cnt_ff, FILT_W'(VCC_OV_FILT));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_cnt_ff <= '0;
        end else begin
            op_cnt_ff <= filt_next(opsup_uv_cmp, op_cnt_ff, FILT_W'(OPSUP_UV_FILT));
        end
    end

    // Flags rise once the count reaches its limit and fall with the comparator.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vcc_uv_ff <= 1'b0;
        end else begin
            vcc_uv_ff <= vcc_uv_raw && (vcc_uv_cnt_ff >= FILT_W'(VCC_UV_FILT - 1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vb_ff <= 1'b0;
        end else begin
            vb_ff <= vb_uv_cmp && (vb_cnt_ff >= FILT_W'(VB_UV_FILT - 1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_ff <= 1'b0;
        end else begin
            cp_ff <= cp_ov_cmp && (cp_cnt_ff >= FILT_W'(CP_OV_FILT - 1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vov_ff <= 1'b0;
        end else begin
            vov_ff <= vcc_ov_cmp && (vov_cnt_ff >= FILT_W'(VCC_OV_FILT - 1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff <= 1'b0;
        end else begin
            op_ff <= opsup_uv_cmp && (op_cnt_ff >= FILT_W'(OPSUP_UV_FILT - 1));
        end
    end

    // Status bits: the fault setting wins over a clear in the same cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vb_uv_stat <= 1'b0;
        end else begin
            vb_uv_stat <= vb_ff | (vb_uv_stat & ~vb_uv_clr);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_ov_stat <= 1'b0;
        end else begin
            cp_ov_stat <= (cp_ff & (cp_mode_ff != SFM_MODE_NOTIFY))
                          | (cp_ov_stat & ~cp_ov_clr);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vcc_ov_stat <= 1'b0;
        end else begin
            vcc_ov_stat <= (vov_ff & (vov_mode_ff != SFM_MODE_NOTIFY))
                           | (vcc_ov_stat & ~vcc_ov_clr);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            opsup_uv_stat <= 1'b0;
        end else begin
            opsup_uv_stat <= (op_ff & (op_mode_ff != SFM_MODE_NOTIFY))
                             | (opsup_uv_stat & ~opsup_uv_clr);
        end
    end

    // Effective modes follow the host only while no fault or status is active.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cp_mode_ff  <= MODE_RESET;
            vov_mode_ff <= MODE_RESET;
            op_mode_ff  <= MODE_RESET;
        end else begin
            if (!cp_ff && !cp_ov_stat) begin
                cp_mode_ff <= cp_ov_mode;
            end
            if (!vov_ff && !vcc_ov_stat) begin
                vov_mode_ff <= vcc_ov_mode;
            end
            if (!op_ff && !opsup_uv_stat) begin
                op_mode_ff <= opsup_uv_mode;
            end
        end
    end

    // VCC undervoltage sequencing with self-test on recovery.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SFM_ST_RUN: begin
                if (vcc_uv_ff) begin
                    nxt_state = SFM_ST_UV;
                end
            end
            SFM_ST_UV: begin
                if (!vcc_uv_ff) begin
                    nxt_state = SFM_ST_BIST;
                end
            end
            SFM_ST_BIST: begin
                if (vcc_uv_ff) begin
                    nxt_state = SFM_ST_UV;
                end else if (self_test_done) begin
                    nxt_state = (logic_self_test && analog_self_test) ? SFM_ST_RUN : SFM_ST_FAIL;
                end
            end
            SFM_ST_FAIL: begin
                if (vcc_uv_ff) begin
                    nxt_state = SFM_ST_UV;
                end
            end
            default: nxt_state = SFM_ST_UV;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SFM_ST_UV;
            start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            start_ff <= (state_ff == SFM_ST_UV) && (nxt_state == SFM_ST_BIST);
        end
    end

    // Per-monitor shutdown decode; mode 101 holds while the status stands.
    function automatic logic [2:0] shut_of(input logic [MODE_W-1:0] m, input logic flt, input logic st);
        logic act;
        act = flt | (st & (m == SFM_MODE_HOLD));
        shut_of = 3'h0;
        case (m)
            SFM_MODE_ALL9:  shut_of = {1'b0, act, act};
            SFM_MODE_MOT6:  shut_of = {1'b0, 1'b0, act};
            SFM_MODE_ALLCP: shut_of = {act, act, act};
            SFM_MODE_HOLD:  shut_of = {act, act, act};
            default:        shut_of = 3'h0;
        endcase
    endfunction : shut_of

    logic [2:0] shut;
    logic       run_ok;
    logic       any_stat;

    assign shut = shut_of(cp_mode_ff, cp_ff, cp_ov_stat)
                | shut_of(vov_mode_ff, vov_ff, vcc_ov_stat)
                | shut_of(op_mode_ff, op_ff, opsup_uv_stat);
    // The filtered flag gates the drivers directly, so they drop in the same cycle as the reset.
    assign run_ok   = (state_ff == SFM_ST_RUN) && !vcc_uv_ff && !vcc_deep_uv;
    assign any_stat = vb_uv_stat | cp_ov_stat | vcc_ov_stat | opsup_uv_stat;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_drv_en <= 1'b0;
            relay_drv_en <= 1'b0;
            cp_en        <= 1'b0;
            osc_en       <= 1'b0;
            por_n        <= 1'b0;
            standby      <= 1'b0;
            diag_out_n   <= 1'b0;
        end else begin
            motor_drv_en <= run_ok && !vb_ff && !shut[0];
            relay_drv_en <= run_ok && !vb_ff && !shut[1];
            cp_en        <= run_ok && !shut[2];
            osc_en       <= !vcc_uv_ff && !vcc_deep_uv;
            por_n        <= !vcc_uv_ff;
            standby      <= vcc_deep_uv;
            diag_out_n   <= (state_ff == SFM_ST_RUN) && !vcc_uv_ff && !any_stat;
        end
    end

    assign vcc_uv_flag_a   = vcc_uv_ff;
    assign vcc_uv_flag_b   = vcc_uv_ff;
    assign vb_uv_flag      = vb_ff;
    assign cp_ov_flag      = cp_ff;
    assign vcc_ov_flag     = vov_ff;
    assign opsup_uv_flag   = op_ff;
    assign self_test_start = start_ff;

endmodule : sfm_supply_fault_monitor

`default_nettype wire

//--- test/sfm_checker.sv
// Port checker for the supply fault monitor.
`timescale 1ns/1ps
`default_nettype none
module sfm_checker #(
    parameter int unsigned VCC_UV_FILT = 4,
    parameter int unsigned VB_UV_FILT  = 4
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Comparators, clear and self-test request.
    input wire logic vcc_uv_cmp_a,
    input wire logic vcc_uv_cmp_b,
    input wire logic vb_uv_cmp,
    input wire logic vb_uv_clr,
    input wire logic self_test_start,
    // Flags, status and responses.
    input wire logic vcc_uv_flag_a,
    input wire logic vcc_uv_flag_b,
    input wire logic vb_uv_flag,
    input wire logic vb_uv_stat,
    input wire logic por_n,
    input wire logic motor_drv_en,
    input wire logic relay_drv_en,
    input wire logic cp_en,
    input wire logic osc_en,
    input wire logic diag_out_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Run counters keep the filter checks free of long repetitions.
    logic [7:0] run_ff;
    logic [7:0] uv_run_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) uv_run_ff <= 8'h0;
        else if (!(vcc_uv_cmp_a || vcc_uv_cmp_b)) uv_run_ff <= 8'h0;
        else if (uv_run_ff != 8'hff) uv_run_ff <= uv_run_ff + 8'h1;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) run_ff <= 8'h0;
        else if (!vb_uv_cmp) run_ff <= 8'h0;
        else if (run_ff != 8'hff) run_ff <= run_ff + 8'h1;
    end
    chk_filter_late: assert property (run_ff >= VB_UV_FILT |-> vb_uv_flag)
        else $error("vb flag late");
    chk_filter_early: assert property (run_ff < VB_UV_FILT |-> !vb_uv_flag)
        else $error("vb flag early");
    chk_flag_drop: assert property (!vb_uv_cmp |=> !vb_uv_flag)
        else $error("vb flag stuck");
    chk_vb_drivers: assert property (vb_uv_flag |=> !motor_drv_en && !relay_drv_en)
        else $error("drivers on in vb fault");
    chk_clear_refused: assert property ($fell(vb_uv_stat) |-> $past(vb_uv_clr) && !$past(vb_uv_flag))
        else $error("vb status lost");
    chk_stat_diag: assert property (vb_uv_stat |=> !diag_out_n)
        else $error("diag high with status");
    chk_uv_shutdown: assert property (vcc_uv_flag_a |=> !por_n && !cp_en && !osc_en && !motor_drv_en
        && !relay_drv_en && !diag_out_n) else $error("no uv shutdown");
    chk_uv_or: assert property ({vcc_uv_flag_a, vcc_uv_flag_b} == {2{uv_run_ff >= VCC_UV_FILT}})
        else $error("uv flags missing");
    chk_test_pulse: assert property (self_test_start |=> !self_test_start)
        else $error("start not a pulse");
    cover property ($rose(vb_uv_stat));
    cover property ($rose(self_test_start));
    cover property ($fell(vcc_uv_flag_a));
endmodule : sfm_checker
bind sfm_supply_fault_monitor sfm_checker #(.VCC_UV_FILT(VCC_UV_FILT), .VB_UV_FILT(VB_UV_FILT)) u_sfm_checker (.*);
`default_nettype wire

//--- test/sfm_test_model.sv
// Self-test engine model answering the monitor.
`timescale 1ns/1ps
`default_nettype none
module sfm_test_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Request and verdict choice.
    input wire logic self_test_start,
    input wire logic pass,
    // Answer.
    output logic     self_test_done,
    output logic     logic_self_test,
    output logic     analog_self_test
);
    logic [3:0] wait_ff;
    // Verdicts read the opposite way outside the done pulse, to catch early sampling.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 4'h0;
            self_test_done <= 1'b0;
            logic_self_test <= 1'b0;
            analog_self_test <= 1'b0;
        end else begin
            wait_ff <= self_test_start ? 4'h5 : (wait_ff != 4'h0 ? wait_ff - 4'h1 : 4'h0);
            self_test_done <= (wait_ff == 4'h1);
            logic_self_test <= (wait_ff == 4'h1) ? pass : !pass;
            analog_self_test <= (wait_ff == 4'h1) ? pass : !pass;
        end
    end
endmodule : sfm_test_model
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the supply fault monitor.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sfm_pkg::*;
    localparam int unsigned FILT = 4;
    logic core_clk = 1'b0, rst_n = 1'b0, ua = 1'b0, ub = 1'b0, deep = 1'b0, vb = 1'b0, vclr = 1'b0, pass = 1'b1;
    logic [2:0] cmp = 3'h0, clr = 3'h0;
    logic [MODE_W-1:0] md [3] = '{3'h0, 3'h0, 3'h0};
    wire st, done, lst, ast, fa, fb, vbs, por_n, stby, mot, rel, cp, osc, diag;
    wire [2:0] stv, fl;
    wire [3:0] outs = {diag, mot, rel, cp};
    int err_count = 0;
    int n_checks = 0;
    initial forever #25 core_clk = ~core_clk;
    sfm_supply_fault_monitor #(.VCC_UV_FILT(FILT), .VB_UV_FILT(FILT), .CP_OV_FILT(FILT), .VCC_OV_FILT(FILT),
        .OPSUP_UV_FILT(FILT)) u_sfm_supply_fault_monitor (.core_clk(core_clk), .rst_n(rst_n),
        .vcc_uv_cmp_a(ua), .vcc_uv_cmp_b(ub), .vcc_deep_uv(deep), .vb_uv_cmp(vb), .cp_ov_cmp(cmp[0]),
        .vcc_ov_cmp(cmp[1]), .opsup_uv_cmp(cmp[2]), .cp_ov_mode(md[0]), .vcc_ov_mode(md[1]),
        .opsup_uv_mode(md[2]), .vb_uv_clr(vclr), .cp_ov_clr(clr[0]), .vcc_ov_clr(clr[1]), .opsup_uv_clr(clr[2]),
        .self_test_start(st), .self_test_done(done), .logic_self_test(lst), .analog_self_test(ast),
        .vcc_uv_flag_a(fa), .vcc_uv_flag_b(fb), .vb_uv_flag(), .cp_ov_flag(fl[0]), .vcc_ov_flag(fl[1]),
        .opsup_uv_flag(fl[2]), .vb_uv_stat(vbs), .cp_ov_stat(stv[0]), .vcc_ov_stat(stv[1]),
        .opsup_uv_stat(stv[2]), .por_n(por_n), .standby(stby), .motor_drv_en(mot), .relay_drv_en(rel),
        .cp_en(cp), .osc_en(osc), .diag_out_n(diag));
    sfm_test_model u_sfm_test_model (.core_clk(core_clk), .rst_n(rst_n), .self_test_start(st), .pass(pass),
        .self_test_done(done), .logic_self_test(lst), .analog_self_test(ast));
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask : step
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run();
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic wait_up();
        for (int k = 0; k < 100 && mot !== 1'b1; k++) step(1);
        chk("motor_drv_en", 4'h1, {3'h0, mot});
        if (mot !== 1'b1) complete_run();
    endtask : wait_up
    task automatic pulse(input int i);
        clr[i] = 1'b1;
        step(1);
        clr[i] = 1'b0;
    endtask : pulse
    initial begin
        step(8);
        rst_n = 1'b1;
        wait_up();
        chk("start", 4'hf, outs);
        cmp[0] = 1'b1;
        step(FILT - 1);
        cmp[0] = 1'b0;
        step(1);
        cmp[0] = 1'b1;
        step(FILT - 1);
        chk("cp_ov_flag", 4'h0, {3'h0, fl[0]});
        cmp[0] = 1'b0;
        vb = 1'b1;
        step(FILT + 3);
        chk("vb_fault", 4'h3, {mot | diag, rel, cp, osc});
        vclr = 1'b1;
        step(1);
        vclr = 1'b0;
        chk("vb_uv_stat", 4'h1, {3'h0, vbs});
        vb = 1'b0;
        step(3);
        chk("vb_resume", 4'h7, outs);
        vclr = 1'b1;
        step(1);
        vclr = 1'b0;
        step(3);
        chk("vb_clear", 4'hf, outs);
        for (int i = 0; i < 3; i++) begin
            for (int m = 0; m < 6; m++) begin
                md[i] = 3'(m);
                step(1);
                cmp[i] = 1'b1;
                step(FILT + 3);
                chk("fault", {m == 0, m < 2, m != 2 && m < 4, m < 4}, outs);
                chk("flag", 4'h1, {3'h0, fl[i]});
                pulse(i);
                chk("stat", {3'h0, m != 0}, {3'h0, stv[i]});
                cmp[i] = 1'b0;
                step(3);
                chk("recover", {m == 0, m != 5, m != 5, m != 5}, outs);
                pulse(i);
                step(3);
                chk("cleared", 4'hf, outs);
            end
        end
        md[1] = 3'h4;
        step(1);
        cmp[1] = 1'b1;
        step(FILT + 3);
        md[1] = 3'h0;
        step(2);
        chk("mode_hold", 4'h0, outs);
        cmp[1] = 1'b0;
        step(3);
        pulse(1);
        step(3);
        cmp[1] = 1'b1;
        step(FILT + 3);
        chk("mode_new", 4'hf, outs);
        cmp[1] = 1'b0;
        pass = 1'b0;
        ub = 1'b1;
        step(FILT + 3);
        chk("uv_state", 4'hc, {fa, fb, por_n, stby});
        chk("uv_out", 4'h0, {diag | cp, mot, rel, osc});
        ub = 1'b0;
        for (int k = 0; k < 50 && done !== 1'b1; k++) step(1);
        chk("self_test_done", 4'h1, {3'h0, done});
        if (done !== 1'b1) complete_run();
        step(3);
        chk("test_fail", 4'h0, outs);
        ua = 1'b1;
        deep = 1'b1;
        step(FILT + 3);
        chk("standby", 4'h8, {stby, osc, cp, mot});
        ua = 1'b0;
        deep = 1'b0;
        pass = 1'b1;
        wait_up();
        chk("test_pass", 4'hf, outs);
        complete_run();
    end
endmodule : tb
`default_nettype wire
